// ### logic/fec_desc_pkg.sv
// Constants, register map and entry layouts for the link FEC descriptor parser.
// Assumes a single hclk domain; shared by the parser, its decoder and the entry interface.
package fec_desc_pkg;

  localparam logic [7:0] DESC_TAG      = 8'hB6;
  localparam logic [2:0] LAST_BYTE_IDX = 3'h7;
  localparam int         FIFO_DEPTH    = 8;
  localparam int         LEVEL_W       = 4;
  localparam int         WORD_W        = 32;

  localparam logic [1:0] ALGO_NONE = 2'h0;
  localparam logic [1:0] ALGO_RS   = 2'h1;
  localparam logic [1:0] ALGO_FC   = 2'h2;

  localparam int ROW_W  = 12;
  localparam int GRAN_W = 6;
  localparam int MS_W   = 14;

  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DCOUNT = 8'h08;
  localparam logic [7:0] REG_ENTRYA = 8'h0C;
  localparam logic [7:0] REG_ENTRYB = 8'h10;
  localparam logic [7:0] REG_POP    = 8'h14;

  localparam int         CTRL_EN_BIT    = 0;
  localparam logic       CTRL_EN_RESET  = 1'b1;
  localparam int         ST_MALFORMED   = 0;
  localparam int         ST_FULL        = 1;
  localparam int         ST_BUSY        = 2;
  localparam int         ST_LEVEL_LO    = 8;
  localparam logic [2:0] HSIZE_WORD     = 3'h2;

  typedef enum logic [2:0] {
    S_TAG,
    S_OTHER_LEN,
    S_LEN,
    S_COUNT,
    S_ENTRY,
    S_PUSH,
    S_SKIP
  } parse_state_t;

  // One 64-bit entry as it arrives, first byte in the top bits
  typedef struct packed {
    logic        path_dir_bit;
    logic        wrap_kind_bit;
    logic [13:0] id_bits;
    logic [1:0]  fec_algo_field;
    logic [1:0]  rsv_bits;
    logic [2:0]  row_count_code;
    logic [2:0]  spread_limit_code;
    logic [5:0]  qos_label_field;
    logic [31:0] tail_ones;
  } raw_entry_t;

  typedef struct packed {
    logic              path_dir_bit;
    logic              wrap_kind_bit;
    logic [13:0]       gse_process_tag;
    logic [1:0]        fec_algo_field;
    logic [2:0]        row_count_code;
    logic [2:0]        spread_limit_code;
    logic [5:0]        qos_label_field;
    logic              tail_ok;
    logic [ROW_W-1:0]  frame_rows;
    logic [GRAN_W-1:0] addr_gran;
    logic [MS_W-1:0]   spread_ms;
  } decoded_entry_t;

  localparam int DEC_W = $bits(decoded_entry_t);

endpackage

// ### logic/entry_if.sv
// Carrier between the parser and its entry decoder: raw bits out, fields back.
// Purely combinational; no clock travels in it.
`timescale 1ns/1ps
interface entry_if;
  fec_desc_pkg::raw_entry_t     raw;
  fec_desc_pkg::decoded_entry_t dec;

  modport decoder (input raw, output dec);
  modport user    (output raw, input dec);
endinterface

// ### logic/entry_decode.sv
// Combinational decoder of one 64-bit descriptor entry into its fields.
// Assumes the raw entry is stable while the parser pushes it.
`timescale 1ns/1ps
module entry_decode (
  entry_if.decoder ent
);

  function automatic logic [fec_desc_pkg::ROW_W-1:0] rows_of(input logic [1:0] algo, input logic [2:0] code);
    rows_of = '0;
    if (algo == fec_desc_pkg::ALGO_RS || algo == fec_desc_pkg::ALGO_FC) begin
      case (code)
        3'h0:    rows_of = 12'h100;
        3'h1:    rows_of = 12'h200;
        3'h2:    rows_of = 12'h300;
        3'h3:    rows_of = 12'h400;
        default: rows_of = '0;
      endcase
    end
    if (algo == fec_desc_pkg::ALGO_FC) begin
      case (code)
        3'h4:    rows_of = 12'h040;
        3'h5:    rows_of = 12'h800;
        3'h6:    rows_of = 12'hFF0;
        default: rows_of = rows_of;
      endcase
    end
  endfunction

  function automatic logic [fec_desc_pkg::GRAN_W-1:0] gran_of(input logic [1:0] algo, input logic [2:0] code);
    gran_of = '0;
    if (algo == fec_desc_pkg::ALGO_RS && code <= 3'h3) begin
      gran_of = 6'h01;
    end else if (algo == fec_desc_pkg::ALGO_FC) begin
      case (code)
        3'h0:    gran_of = 6'h02;
        3'h1:    gran_of = 6'h04;
        3'h2:    gran_of = 6'h06;
        3'h3:    gran_of = 6'h08;
        3'h4:    gran_of = 6'h01;
        3'h5:    gran_of = 6'h10;
        3'h6:    gran_of = 6'h20;
        default: gran_of = '0;
      endcase
    end
  endfunction

  // Unspecified and reserved codes both read back as zero milliseconds
  function automatic logic [fec_desc_pkg::MS_W-1:0] ms_of(input logic [2:0] code);
    case (code)
      3'h0:    ms_of = 14'h000A;
      3'h1:    ms_of = 14'h0028;
      3'h2:    ms_of = 14'h00A0;
      3'h3:    ms_of = 14'h0280;
      3'h4:    ms_of = 14'h0A00;
      3'h5:    ms_of = 14'h2800;
      default: ms_of = '0;
    endcase
  endfunction

  always_comb begin
    ent.dec.path_dir_bit      = ent.raw.path_dir_bit;
    ent.dec.wrap_kind_bit     = ent.raw.wrap_kind_bit;
    // Leading reserved bit dropped for the 13-bit stream_pid_field layout
    ent.dec.gse_process_tag   = ent.raw.wrap_kind_bit ? ent.raw.id_bits : {1'b0, ent.raw.id_bits[12:0]};
    ent.dec.fec_algo_field    = ent.raw.fec_algo_field;
    ent.dec.row_count_code    = ent.raw.row_count_code;
    ent.dec.spread_limit_code = ent.raw.spread_limit_code;
    ent.dec.qos_label_field   = ent.raw.qos_label_field;
    ent.dec.tail_ok           = &ent.raw.tail_ones;
    ent.dec.frame_rows        = rows_of(ent.raw.fec_algo_field, ent.raw.row_count_code);
    ent.dec.addr_gran         = gran_of(ent.raw.fec_algo_field, ent.raw.row_count_code);
    ent.dec.spread_ms         = ms_of(ent.raw.spread_limit_code);
  end

endmodule

// ### logic/sync_fifo.sv
// Single-clock FIFO with valid/ready on both sides and a fill level.
// Pushes into a full FIFO and pops from an empty one are refused by ready/valid.
`timescale 1ns/1ps
module sync_fifo #(
  parameter int WIDTH = 63,
  parameter int DEPTH = 8
) (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       clk_en,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  output logic [$clog2(DEPTH):0]          level
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             do_push;
  logic             do_pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready  = count_ff != (AW+1)'(DEPTH);
  assign out_valid = count_ff != '0;
  assign out_data  = mem[rd_ptr_ff];
  assign level     = count_ff;
  assign do_push   = clk_en && in_valid && in_ready;
  assign do_pop    = clk_en && out_valid && out_ready;

  always_ff @(posedge hclk) begin
    if (do_push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_ff <= bump(wr_ptr_ff);
      end
      if (do_pop) begin
        rd_ptr_ff <= bump(rd_ptr_ff);
      end
      if (do_push && !do_pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (do_pop && !do_push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

endmodule

// ### logic/link_fec_descriptor_parser.sv
// Parser for link FEC descriptors arriving as a byte stream, with AHB-Lite registers.
// Bytes come from a section filter on hclk; descriptors follow each other back to back.
`timescale 1ns/1ps

// Overview of operation
// - The length byte counts the following bytes and bounds body parsing.
// - The count byte after the length gives exactly how many entries to decode.
// - First entry bit: 0 forward link, 1 return link.
// - Wrap bit 0: reserved bit then 13-bit stream id; 1: 14-bit process tag.
// - The 14-bit process tag identifies one FEC process for its frames.
// - Two-bit algorithm: none, Reed-Solomon, fountain code, reserved.
// - Reed-Solomon row codes 0 to 3 give 256 to 1024 rows; rest reserved.
// - Fountain row codes add 64, 2048 and 4080 rows; code 7 reserved.
// - Granularity is 1 for Reed-Solomon; fountain codes map to 2,4,6,8,1,16,32.
// - Two reserved bits before the row code, and all reserved bits, are ignored.
// - Spread code maps to 10 up to 10240 ms; 6 unspecified, 7 reserved.
// - The six-bit QoS label is captured as is, never interpreted.
module link_fec_descriptor_parser (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   clk_en,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic [31:0]                 hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  input  wire logic                   byte_valid,
  input  wire logic [7:0]             byte_data,
  output logic                        byte_ready,
  output logic                        entry_valid,
  output fec_desc_pkg::decoded_entry_t entry_word,
  output logic                        malformed
);

  fec_desc_pkg::parse_state_t   state_ff;
  logic [7:0]                   body_len_ff;
  logic [7:0]                   remain_ff;
  logic [7:0]                   entries_left_ff;
  logic [2:0]                   byte_idx_ff;
  logic [63:0]                  shift_ff;
  logic                         entry_valid_ff;
  fec_desc_pkg::decoded_entry_t entry_word_ff;
  logic                         malformed_ff;
  logic                         enable_ff;
  logic [15:0]                  desc_count_ff;
  logic                         wr_pend_ff;
  logic [7:0]                   wr_addr_ff;
  logic [31:0]                  hrdata_ff;
  logic [31:0]                  rd_mux;
  logic                         accept;
  logic                         push;
  logic                         addr_phase;
  logic                         pop;
  logic                         clear_malformed;
  logic                         set_malformed;
  logic                         fifo_in_ready;
  logic                         fifo_out_valid;
  logic [fec_desc_pkg::DEC_W-1:0] fifo_out_data;
  logic [fec_desc_pkg::LEVEL_W-1:0] fifo_level;
  logic [2*fec_desc_pkg::WORD_W-1:0] head_words;

  entry_if ent ();

  entry_decode u_decode (
    .ent (ent)
  );

  // Eight bytes per counted entry plus the count byte itself must fit in the body
  function automatic logic body_fits(input logic [7:0] cnt, input logic [7:0] len);
    body_fits = ({cnt, 3'h0} + 11'h001) <= {3'h0, len};
  endfunction

  assign ent.raw = fec_desc_pkg::raw_entry_t'(shift_ff);

  // Stall the stream while an entry waits for FIFO room
  assign byte_ready = clk_en && enable_ff && (state_ff != fec_desc_pkg::S_PUSH);
  assign accept     = byte_valid && byte_ready;
  assign push       = clk_en && (state_ff == fec_desc_pkg::S_PUSH) && fifo_in_ready;

  assign entry_valid = entry_valid_ff;
  assign entry_word  = entry_word_ff;
  assign malformed   = malformed_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff        <= fec_desc_pkg::S_TAG;
      body_len_ff     <= '0;
      remain_ff       <= '0;
      entries_left_ff <= '0;
      byte_idx_ff     <= '0;
    end else if (clk_en) begin
      case (state_ff)
        fec_desc_pkg::S_TAG: begin
          if (accept) begin
            state_ff <= (byte_data == fec_desc_pkg::DESC_TAG) ? fec_desc_pkg::S_LEN : fec_desc_pkg::S_OTHER_LEN;
          end
        end
        fec_desc_pkg::S_OTHER_LEN: begin
          if (accept) begin
            remain_ff <= byte_data;
            state_ff  <= (byte_data == '0) ? fec_desc_pkg::S_TAG : fec_desc_pkg::S_SKIP;
          end
        end
        fec_desc_pkg::S_LEN: begin
          if (accept) begin
            body_len_ff <= byte_data;
            remain_ff   <= byte_data;
            state_ff    <= (byte_data == '0) ? fec_desc_pkg::S_TAG : fec_desc_pkg::S_COUNT;
          end
        end
        fec_desc_pkg::S_COUNT: begin
          if (accept) begin
            remain_ff       <= remain_ff - 1'b1;
            entries_left_ff <= byte_data;
            byte_idx_ff     <= '0;
            if (!body_fits(byte_data, body_len_ff) || byte_data == '0) begin
              state_ff <= (remain_ff == 8'h01) ? fec_desc_pkg::S_TAG : fec_desc_pkg::S_SKIP;
            end else begin
              state_ff <= fec_desc_pkg::S_ENTRY;
            end
          end
        end
        fec_desc_pkg::S_ENTRY: begin
          if (accept) begin
            remain_ff   <= remain_ff - 1'b1;
            byte_idx_ff <= byte_idx_ff + 1'b1;
            if (byte_idx_ff == fec_desc_pkg::LAST_BYTE_IDX) begin
              state_ff <= fec_desc_pkg::S_PUSH;
            end
          end
        end
        fec_desc_pkg::S_PUSH: begin
          if (fifo_in_ready) begin
            entries_left_ff <= entries_left_ff - 1'b1;
            byte_idx_ff     <= '0;
            if (entries_left_ff != 8'h01) begin
              state_ff <= fec_desc_pkg::S_ENTRY;
            end else begin
              // Trailing extension bytes are consumed, not decoded
              state_ff <= (remain_ff == '0) ? fec_desc_pkg::S_TAG : fec_desc_pkg::S_SKIP;
            end
          end
        end
        fec_desc_pkg::S_SKIP: begin
          if (accept) begin
            remain_ff <= remain_ff - 1'b1;
            if (remain_ff == 8'h01) begin
              state_ff <= fec_desc_pkg::S_TAG;
            end
          end
        end
        default: state_ff <= fec_desc_pkg::S_TAG;
      endcase
    end
  end

  // Bytes enter at the bottom, so the first byte ends up in the top bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_ff <= '0;
    end else if (clk_en && accept && state_ff == fec_desc_pkg::S_ENTRY) begin
      shift_ff <= {shift_ff[55:0], byte_data};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      entry_valid_ff <= 1'b0;
      entry_word_ff  <= '0;
    end else if (clk_en) begin
      entry_valid_ff <= push;
      if (push) begin
        entry_word_ff <= ent.dec;
      end
    end
  end

  assign set_malformed = accept &&
                         ((state_ff == fec_desc_pkg::S_LEN && byte_data == '0) ||
                          (state_ff == fec_desc_pkg::S_COUNT && !body_fits(byte_data, body_len_ff)));

  // Sticky; a new fault in the clearing cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      malformed_ff <= 1'b0;
    end else if (clk_en) begin
      if (set_malformed) begin
        malformed_ff <= 1'b1;
      end else if (clear_malformed) begin
        malformed_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      desc_count_ff <= '0;
    end else if (clk_en && accept && state_ff == fec_desc_pkg::S_TAG && byte_data == fec_desc_pkg::DESC_TAG) begin
      desc_count_ff <= desc_count_ff + 1'b1;
    end
  end

  sync_fifo #(
    .WIDTH (fec_desc_pkg::DEC_W),
    .DEPTH (fec_desc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .clk_en    (clk_en),
    .in_valid  (state_ff == fec_desc_pkg::S_PUSH),
    .in_ready  (fifo_in_ready),
    .in_data   (ent.dec),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  // AHB-Lite slave: zero wait states unless clk_en is low
  assign hreadyout       = clk_en;
  assign hresp           = 1'b0;
  assign hrdata          = hrdata_ff;
  assign addr_phase      = hsel && htrans[1] && hready;
  assign pop             = clk_en && wr_pend_ff && wr_addr_ff == fec_desc_pkg::REG_POP;
  assign clear_malformed = wr_pend_ff && wr_addr_ff == fec_desc_pkg::REG_STATUS && hwdata[fec_desc_pkg::ST_MALFORMED];
  // Head valid closes the first word so the second holds rows, granularity and spread whole
  assign head_words      = {fifo_out_data[fec_desc_pkg::DEC_W-1:fec_desc_pkg::WORD_W], fifo_out_valid,
                            fifo_out_data[fec_desc_pkg::WORD_W-1:0]};

  always_comb begin
    rd_mux = '0;
    case (haddr[7:0])
      fec_desc_pkg::REG_CTRL:   rd_mux[fec_desc_pkg::CTRL_EN_BIT] = enable_ff;
      fec_desc_pkg::REG_STATUS: begin
        rd_mux[fec_desc_pkg::ST_MALFORMED] = malformed_ff;
        rd_mux[fec_desc_pkg::ST_FULL]      = !fifo_in_ready;
        rd_mux[fec_desc_pkg::ST_BUSY]      = state_ff != fec_desc_pkg::S_TAG;
        rd_mux[fec_desc_pkg::ST_LEVEL_LO +: fec_desc_pkg::LEVEL_W] = fifo_level;
      end
      fec_desc_pkg::REG_DCOUNT: rd_mux[15:0] = desc_count_ff;
      fec_desc_pkg::REG_ENTRYA: rd_mux = head_words[2*fec_desc_pkg::WORD_W-1 -: fec_desc_pkg::WORD_W];
      fec_desc_pkg::REG_ENTRYB: rd_mux = head_words[fec_desc_pkg::WORD_W-1:0];
      default:                  rd_mux = '0;
    endcase
    if (haddr[31:8] != '0) begin
      rd_mux = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
      hrdata_ff  <= '0;
    end else if (clk_en) begin
      wr_pend_ff <= addr_phase && hwrite && hsize == fec_desc_pkg::HSIZE_WORD && haddr[31:8] == '0;
      wr_addr_ff <= haddr[7:0];
      if (addr_phase && !hwrite) begin
        hrdata_ff <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_ff <= fec_desc_pkg::CTRL_EN_RESET;
    end else if (clk_en && wr_pend_ff && wr_addr_ff == fec_desc_pkg::REG_CTRL) begin
      enable_ff <= hwdata[fec_desc_pkg::CTRL_EN_BIT];
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_last_byte;
    state_ff == fec_desc_pkg::S_ENTRY && accept && byte_idx_ff == fec_desc_pkg::LAST_BYTE_IDX;
  endsequence

  sequence s_push;
    push;
  endsequence

  chk_tag_gate: assert property (
    state_ff == fec_desc_pkg::S_TAG && accept && byte_data != fec_desc_pkg::DESC_TAG
    |=> state_ff == fec_desc_pkg::S_OTHER_LEN)
    else $error("non-matching tag not skipped");

  chk_body_bound: assert property (
    accept && (state_ff == fec_desc_pkg::S_COUNT || state_ff == fec_desc_pkg::S_ENTRY ||
               state_ff == fec_desc_pkg::S_SKIP) |-> remain_ff != '0)
    else $error("body byte taken past the length");

  chk_count_exact: assert property (
    push && entries_left_ff == 8'h01 |=> state_ff != fec_desc_pkg::S_ENTRY)
    else $error("entry decoded beyond the count");

  chk_entry_width: assert property (
    s_last_byte ##1 s_push |=> entry_valid_ff ##1 !entry_valid_ff)
    else $error("entry strobe not a single cycle after eight bytes");

  chk_push_stall: assert property (
    state_ff == fec_desc_pkg::S_PUSH && !fifo_in_ready |-> !byte_ready ##1 state_ff == fec_desc_pkg::S_PUSH)
    else $error("stream not stalled while the FIFO is full");

  chk_malformed_flag: assert property (
    state_ff == fec_desc_pkg::S_COUNT && accept && !body_fits(byte_data, body_len_ff)
    |=> malformed_ff && state_ff != fec_desc_pkg::S_ENTRY)
    else $error("oversized entry count not flagged");

  chk_rs_gran: assert property (
    entry_valid_ff && entry_word_ff.fec_algo_field == fec_desc_pkg::ALGO_RS && entry_word_ff.frame_rows != '0
    |-> entry_word_ff.addr_gran == 6'h01)
    else $error("Reed-Solomon granularity not one");

  chk_fc_rows: assert property (
    entry_valid_ff && entry_word_ff.fec_algo_field == fec_desc_pkg::ALGO_FC && entry_word_ff.row_count_code == 3'h4
    |-> entry_word_ff.frame_rows == 12'h040 && entry_word_ff.addr_gran == 6'h01)
    else $error("fountain code 4 not 64 rows");

  chk_spread_ms: assert property (
    entry_valid_ff && entry_word_ff.spread_limit_code == 3'h3 |-> entry_word_ff.spread_ms == 14'h0280)
    else $error("spread code 3 not 640 ms");

  chk_pid_layout: assert property (
    entry_valid_ff && !entry_word_ff.wrap_kind_bit |-> !entry_word_ff.gse_process_tag[13])
    else $error("reserved bit leaked into stream id");

endmodule

// ### bench/desc_source.sv
// Control centre model: emits descriptors as bytes on a valid/ready link.
// Assumes the parser samples byte_valid and byte_ready at rising hclk.
`timescale 1ns/1ps
module desc_source (
  input  wire logic  hclk,
  input  wire logic  byte_ready,
  output logic       byte_valid,
  output logic [7:0] byte_data
);
  initial begin
    byte_valid = 1'b0;
    byte_data  = 8'h00;
  end

  // Body is cut to len bytes, so a short length truncates the entries
  task automatic send_desc(input logic [7:0] tag, input logic [7:0] len, input logic [7:0] cnt,
                           input logic [63:0] ent[$]);
    logic [7:0] q[$];
    q = {cnt};
    foreach (ent[i]) for (int b = 7; b >= 0; b--) q.push_back(ent[i][8*b +: 8]);
    while (q.size() < len) q.push_back(8'hFF);
    q = {tag, len, q[0:len-1]};
    foreach (q[i]) begin
      byte_valid <= 1'b1;
      byte_data  <= q[i];
      @(posedge hclk);
      while (byte_ready !== 1'b1) @(posedge hclk);
    end
    byte_valid <= 1'b0;  // Valid drops after the last byte of each descriptor
    // Idle data never repeats the last byte
    byte_data  <= ~byte_data;
    // One idle edge, so a following call never drives valid twice at once
    @(posedge hclk);
  endtask
endmodule

// ### bench/tb_top.sv
// Self-checking bench for the descriptor parser: bytes in, FIFO drained over AHB-Lite.
// Assumes one 40 MHz hclk and the desc_source model on the byte side.
`timescale 1ns/1ps
module tb_top;
  logic                         hclk;
  logic                         hresetn;
  logic                         hsel;
  logic [31:0]                  haddr;
  logic [1:0]                   htrans;
  logic                         hwrite;
  logic [31:0]                  hwdata;
  logic [31:0]                  hrdata;
  logic                         hreadyout;
  logic                         hresp;
  logic                         byte_valid;
  logic [7:0]                   byte_data;
  logic                         byte_ready;
  logic                         entry_valid;
  logic                         malformed;
  fec_desc_pkg::decoded_entry_t entry_word;
  fec_desc_pkg::decoded_entry_t got[$];
  int                           n_fail;
  int                           checks;
  int                           ntags;

  link_fec_descriptor_parser dut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(fec_desc_pkg::HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .byte_valid(byte_valid), .byte_data(byte_data),
    .byte_ready(byte_ready), .entry_valid(entry_valid), .entry_word(entry_word), .malformed(malformed));
  desc_source src (.hclk(hclk), .byte_ready(byte_ready), .byte_valid(byte_valid), .byte_data(byte_data));

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  always @(posedge hclk) if (entry_valid === 1'b1) got.push_back(entry_word);

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, exp);
    chk(hresp, 1'b0);
  endtask

  function automatic logic [31:0] dec_exp(input logic [1:0] a, input logic [2:0] c);
    logic [11:0] rows;
    logic [5:0]  gran;
    logic [13:0] ms;
    rows = (c < 4) ? 12'(256 * (c + 1)) : (c == 4) ? 12'h040 : (c == 5) ? 12'h800 : (c == 6) ? 12'hFF0 : 12'h0;
    gran = (c < 4) ? 6'(2 * (c + 1)) : (c == 4) ? 6'h01 : (c == 5) ? 6'h10 : (c == 6) ? 6'h20 : 6'h0;
    ms = (c < 6) ? 14'(10 << (2 * c)) : 14'h0;
    if (a == fec_desc_pkg::ALGO_RS && c > 3) rows = 12'h0;
    if (a == fec_desc_pkg::ALGO_RS) gran = (c < 4) ? 6'h01 : 6'h00;
    // Spread decodes whatever the algorithm; rows and granularity only for a coded stream
    if (a != fec_desc_pkg::ALGO_RS && a != fec_desc_pkg::ALGO_FC) {rows, gran} = 18'h0;
    return {rows, gran, ms};
  endfunction

  // Eight entries fill the FIFO; two spare body bytes must be skipped
  task automatic run_algo(input logic [1:0] a);
    logic [63:0] ent[$];
    logic [13:0] id;
    logic [62:0] e;
    logic [31:0] r;
    for (int i = 0; i < 8; i++) begin
      id = {~i[0], 13'(13'h0A5 + i)};
      ent.push_back({i[1], i[0], id, a, 2'(~i), 3'(i), 3'(i), 6'(5 * i), 32'hFFFF_FFFF});
    end
    src.send_desc(8'hB6, 8'd67, 8'd8, ent);
    ntags++;
    for (int k = 0; k < 100 && got.size() < 8; k++) @(posedge hclk);
    chk(got.size(), 8);
    for (int i = 0; i < 8 && i < got.size(); i++) begin
      id = ent[i][61:48];
      e = {i[1], i[0], i[0] ? id : {1'b0, id[12:0]}, a, 3'(i), 3'(i), 6'(5 * i), 1'b1, dec_exp(a, 3'(i))};
      chk(got[i], e);
    end
    rd_chk(fec_desc_pkg::REG_STATUS, 32'h0000_0802);
    rd_chk(fec_desc_pkg::REG_ENTRYA, {2'h0, 14'h00A5, a, 12'h000, 2'h3});
    rd_chk(fec_desc_pkg::REG_ENTRYB, dec_exp(a, 3'h0));
    repeat (8) bus(1'b1, fec_desc_pkg::REG_POP, 32'h1, r);
    rd_chk(fec_desc_pkg::REG_STATUS, 32'h0);
    chk(got.size(), 8);
    got.delete();
  endtask

  task automatic run_bad();
    logic [63:0] ent[$];
    logic [31:0] r;
    ent.push_back(64'h0);
    src.send_desc(8'h5A, 8'd9, 8'd1, ent);
    src.send_desc(8'hB6, 8'd8, 8'd1, ent);
    ntags++;
    repeat (4) @(posedge hclk);
    chk(malformed, 1'b1);
    chk(got.size(), 0);
    rd_chk(fec_desc_pkg::REG_STATUS, 32'h1);
    rd_chk(fec_desc_pkg::REG_DCOUNT, 32'(ntags));
    bus(1'b1, fec_desc_pkg::REG_STATUS, 32'h1, r);
    rd_chk(fec_desc_pkg::REG_STATUS, 32'h0);
    rd_chk(8'h40, 32'h0);
  endtask

  task automatic finish_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    #500000;
    n_fail++;
    finish_test();
  end

  initial begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hwdata  = 32'h0;
    n_fail  = 0;
    checks  = 0;
    ntags   = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(fec_desc_pkg::REG_CTRL, 32'h1);
    run_bad();
    for (int a = 0; a < 4; a++) run_algo(2'(a));
    finish_test();
  end
endmodule
